// file: verilog/pirb_pkg.sv
`default_nettype none
package pirb_pkg;

   // ==========================================================
   // Widths
   localparam int PIRB_REG_W = 16;
   localparam int PIRB_SRC_N = 48;
   localparam int PIRB_LVL_N = 6;
   localparam int PIRB_ADDR_W = 18;
   localparam int PIRB_DATA_W = 32;
   localparam int PIRB_IDX_LSB = 2;
   localparam int PIRB_EVT_W = 3;

   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [15:0] PIRB_IDX_REQ0 = 16'h7010;
   localparam logic [15:0] PIRB_IDX_REQ1 = 16'h7011;
   localparam logic [15:0] PIRB_IDX_REQ2 = 16'h7012;
   localparam logic [15:0] PIRB_IDX_ACK0 = 16'h7014;
   localparam logic [15:0] PIRB_IDX_ACK1 = 16'h7015;
   localparam logic [15:0] PIRB_IDX_ACK2 = 16'h7016;
   localparam logic [15:0] PIRB_IDX_VEC = 16'h701e;
   localparam logic [15:0] PIRB_IDX_EVT_STAT = 16'h7020;
   localparam logic [15:0] PIRB_IDX_EVT_CLR = 16'h7021;
   localparam logic [15:0] PIRB_IDX_EVT_EN = 16'h7022;

   // ==========================================================
   // Implemented bits and reset values
   localparam logic [15:0] PIRB_IMPL0 = 16'hffff;
   localparam logic [15:0] PIRB_IMPL1 = 16'h7fff;
   localparam logic [15:0] PIRB_IMPL2 = 16'h7fff;
   localparam logic [47:0] PIRB_IMPL = {PIRB_IMPL2, PIRB_IMPL1, PIRB_IMPL0};
   localparam logic [47:0] PIRB_PEND_RST = 48'h0000_0000_0000;
   localparam logic [15:0] PIRB_VEC_RST = 16'h0000;
   localparam logic [2:0] PIRB_EVT_RST = 3'h0;

   // ==========================================================
   // Source to core level map, index 0 is level one
   localparam logic [5:0][47:0] PIRB_LEVEL_MAP = {
      48'h0000_7000_0000,
      48'h0000_0f80_0000,
      48'h7000_0070_0000,
      48'h0f00_000f_0000,
      48'h00fe_0000_fe00,
      48'h0001_0000_01ff};
   localparam logic [2:0] PIRB_LVL_MIN = 3'h1;
   localparam logic [2:0] PIRB_LVL_MAX = 3'h6;

   // ==========================================================
   // Event status bits
   localparam int PIRB_EVT_ACK = 0;
   localparam int PIRB_EVT_PHANTOM = 1;
   localparam int PIRB_EVT_OVERRUN = 2;

   // ==========================================================
   // Bus answers and slave states
   localparam logic [1:0] PIRB_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIRB_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PIRB_ST_IDLE = 3'h0,
      PIRB_ST_WSTB = 3'h1,
      PIRB_ST_BRESP = 3'h3,
      PIRB_ST_RSTB = 3'h4,
      PIRB_ST_RRESP = 3'h5
   } pirb_axi_state_t;

   // ==========================================================
   // Helpers
   function automatic logic [5:0] pirb_level_hits(input logic [47:0] pend);
      logic [5:0] hits;
      hits = 6'h00;
      for (int l = 0; l < PIRB_LVL_N; l++) begin
         hits[l] = |(pend & PIRB_LEVEL_MAP[l]);
      end
      return hits;
   endfunction

   function automatic logic [15:0] pirb_strb_mask(input logic [3:0] strb);
      return {{8{strb[1]}}, {8{strb[0]}}};
   endfunction

endpackage
`default_nettype wire

// file: verilog/pirb_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pirb_reg_if;
   logic wr_stb;
   logic rd_stb;
   logic [15:0] idx;
   logic [15:0] wdata;
   logic [15:0] wmask;
   logic [15:0] rdata;
   logic hit;

   modport slave (output wr_stb, output rd_stb, output idx, output wdata, output wmask,
      input rdata, input hit);
   modport regs (input wr_stb, input rd_stb, input idx, input wdata, input wmask,
      output rdata, output hit);
endinterface
`default_nettype wire

// file: verilog/pirb_prio.sv
`timescale 1ns/1ps
`default_nettype none
module pirb_prio
   import pirb_pkg::*;
(
   input wire logic [47:0] pend_i,
   input wire logic [2:0] level_i,
   output logic found_o,
   output logic [5:0] idx_o
);
   logic level_ok;
   logic [2:0] level_sel;
   logic [47:0] cand;

   assign level_ok = (level_i >= PIRB_LVL_MIN) && (level_i <= PIRB_LVL_MAX);
   assign level_sel = 3'(level_i - PIRB_LVL_MIN);
   assign cand = level_ok ? (pend_i & PIRB_LEVEL_MAP[level_sel]) : 48'h0;

   // ==========================================================
   // Lowest bit number is the highest priority on a level
   always_comb begin
      found_o = 1'b0;
      idx_o = 6'h00;
      for (int i = PIRB_SRC_N - 1; i >= 0; i--) begin
         if (cand[i]) begin
            found_o = 1'b1;
            idx_o = 6'(i);
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/pirb_axil.sv
`timescale 1ns/1ps
`default_nettype none
module pirb_axil
   import pirb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [17:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [17:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   pirb_reg_if.slave rif
);
   pirb_axi_state_t state, next_state;
   logic have_aw, have_w, next_have_aw, next_have_w;
   logic [15:0] aw_idx, ar_idx, w_data, w_mask;
   logic aw_hs, w_hs, ar_hs, in_idle, in_wstb;

   assign aw_hs = awvalid_i && awready_o;
   assign w_hs = wvalid_i && wready_o;
   assign ar_hs = arvalid_i && arready_o;
   assign in_idle = (state == PIRB_ST_IDLE);
   assign in_wstb = (state == PIRB_ST_WSTB);
   assign next_have_aw = (have_aw || aw_hs) && !in_wstb;
   assign next_have_w = (have_w || w_hs) && !in_wstb;

   assign rif.wr_stb = in_wstb;
   assign rif.rd_stb = (state == PIRB_ST_RSTB);
   assign rif.idx = in_wstb ? aw_idx : ar_idx;
   assign rif.wdata = w_data;
   assign rif.wmask = w_mask;

   // ==========================================================
   // Sequencer: a read taken in idle goes before a pending write
   always_comb begin
      next_state = state;
      case (state)
         PIRB_ST_IDLE: begin
            if (ar_hs) begin
               next_state = PIRB_ST_RSTB;
            end else if (have_aw && have_w) begin
               next_state = PIRB_ST_WSTB;
            end
         end
         PIRB_ST_WSTB: next_state = PIRB_ST_BRESP;
         PIRB_ST_BRESP: begin
            if (bready_i) begin
               next_state = PIRB_ST_IDLE;
            end
         end
         PIRB_ST_RSTB: next_state = PIRB_ST_RRESP;
         PIRB_ST_RRESP: begin
            if (rready_i) begin
               next_state = PIRB_ST_IDLE;
            end
         end
         default: next_state = PIRB_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state <= PIRB_ST_IDLE;
         have_aw <= 1'b0;
         have_w <= 1'b0;
         awready_o <= 1'b0;
         wready_o <= 1'b0;
         arready_o <= 1'b0;
         bvalid_o <= 1'b0;
         rvalid_o <= 1'b0;
         bresp_o <= PIRB_RESP_OKAY;
         rresp_o <= PIRB_RESP_OKAY;
         rdata_o <= 32'h0;
         aw_idx <= 16'h0;
         ar_idx <= 16'h0;
         w_data <= 16'h0;
         w_mask <= 16'h0;
      end else begin
         state <= next_state;
         have_aw <= next_have_aw;
         have_w <= next_have_w;
         awready_o <= !next_have_aw;
         wready_o <= !next_have_w;
         arready_o <= (next_state == PIRB_ST_IDLE) && !(next_have_aw && next_have_w);
         if (aw_hs) begin
            aw_idx <= awaddr_i[PIRB_ADDR_W-1:PIRB_IDX_LSB];
         end
         if (w_hs) begin
            w_data <= wdata_i[PIRB_REG_W-1:0];
            w_mask <= pirb_strb_mask(wstrb_i);
         end
         if (ar_hs) begin
            ar_idx <= araddr_i[PIRB_ADDR_W-1:PIRB_IDX_LSB];
         end
         if (in_wstb) begin
            bvalid_o <= 1'b1;
            bresp_o <= rif.hit ? PIRB_RESP_OKAY : PIRB_RESP_SLVERR;
         end else if (bready_i) begin
            bvalid_o <= 1'b0;
         end
         if (state == PIRB_ST_RSTB) begin
            rvalid_o <= 1'b1;
            rresp_o <= rif.hit ? PIRB_RESP_OKAY : PIRB_RESP_SLVERR;
            rdata_o <= {16'h0, rif.rdata};
         end else if (rready_i) begin
            rvalid_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/pirb_bank.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Each implemented request bit reads 1 while its source is pending and 0 otherwise.
// R2: Writing 1 to an implemented request bit makes it pending and raises its core level.
// R3: Writing 0 to a request bit changes nothing, so software can only add requests.
// R4: Bit 15 of the second and third request registers reads zero and ignores writes.
// R5: All implemented request bits clear to zero on reset.
// R6: First register bits 0 to 8 drive core level one.
// R7: First register bits 9 to 15 drive core level two.
// R8: Second register bits 0 to 3 drive level three and bits 4 to 6 drive level four.
// R9: Second register bits 7 to 11 drive core level five.
// R10: Second register bits 12 to 14 drive core level six.
// R11: Third register bit 0 drives core level one.
// R12: Third register bits 1 to 7 drive core level two.
// R13: Third register bits 8 to 11 drive level three and bits 12 to 14 drive level four.
// R14: A core acknowledge of a level loads the vector of its best pending source, or phantom.
// R15: An acknowledge for a source, by the core or by software, clears its pending bit.
// R16: A core level output is high exactly while some pending bit mapped to it is set.
module pirb_bank
   import pirb_pkg::*;
#(
   // Arbitrary vector numbering
   parameter logic [15:0] VECTOR_BASE = 16'h0001,
   parameter logic [15:0] PHANTOM_VECTOR = 16'h0000
) (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic [17:0] AXI_AWADDR_I,
   input wire logic AXI_AWVALID_I,
   output logic AXI_AWREADY_O,
   input wire logic [31:0] AXI_WDATA_I,
   input wire logic [3:0] AXI_WSTRB_I,
   input wire logic AXI_WVALID_I,
   output logic AXI_WREADY_O,
   output logic [1:0] AXI_BRESP_O,
   output logic AXI_BVALID_O,
   input wire logic AXI_BREADY_I,
   input wire logic [17:0] AXI_ARADDR_I,
   input wire logic AXI_ARVALID_I,
   output logic AXI_ARREADY_O,
   output logic [31:0] AXI_RDATA_O,
   output logic [1:0] AXI_RRESP_O,
   output logic AXI_RVALID_O,
   input wire logic AXI_RREADY_I,
   input wire logic [47:0] SRC_REQ_I,
   output logic [47:0] SRC_ACK_O,
   input wire logic CORE_ACK_I,
   input wire logic [2:0] CORE_ACK_LEVEL_I,
   output logic [5:0] CORE_LEVEL_O,
   output logic [15:0] VECTOR_O,
   output logic IRQ_O
);
   // ==========================================================
   // Register bus
   pirb_reg_if rif ();

   pirb_axil u_axil (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .awaddr_i(AXI_AWADDR_I),
      .awvalid_i(AXI_AWVALID_I),
      .awready_o(AXI_AWREADY_O),
      .wdata_i(AXI_WDATA_I),
      .wstrb_i(AXI_WSTRB_I),
      .wvalid_i(AXI_WVALID_I),
      .wready_o(AXI_WREADY_O),
      .bresp_o(AXI_BRESP_O),
      .bvalid_o(AXI_BVALID_O),
      .bready_i(AXI_BREADY_I),
      .araddr_i(AXI_ARADDR_I),
      .arvalid_i(AXI_ARVALID_I),
      .arready_o(AXI_ARREADY_O),
      .rdata_o(AXI_RDATA_O),
      .rresp_o(AXI_RRESP_O),
      .rvalid_o(AXI_RVALID_O),
      .rready_i(AXI_RREADY_I),
      .rif(rif.slave)
   );

   // ==========================================================
   // State
   logic [47:0] pend, next_pend;
   logic [15:0] vector, next_vector;
   logic [2:0] evt_status, next_evt_status;
   logic [2:0] evt_enable, next_evt_enable;

   // ==========================================================
   // Address decode
   logic sel_req0, sel_req1, sel_req2;
   logic sel_ack0, sel_ack1, sel_ack2;
   logic sel_vec, sel_stat, sel_clr, sel_en;
   logic [15:0] wr_bits;

   assign sel_req0 = (rif.idx == PIRB_IDX_REQ0);
   assign sel_req1 = (rif.idx == PIRB_IDX_REQ1);
   assign sel_req2 = (rif.idx == PIRB_IDX_REQ2);
   assign sel_ack0 = (rif.idx == PIRB_IDX_ACK0);
   assign sel_ack1 = (rif.idx == PIRB_IDX_ACK1);
   assign sel_ack2 = (rif.idx == PIRB_IDX_ACK2);
   assign sel_vec = (rif.idx == PIRB_IDX_VEC);
   assign sel_stat = (rif.idx == PIRB_IDX_EVT_STAT);
   assign sel_clr = (rif.idx == PIRB_IDX_EVT_CLR);
   assign sel_en = (rif.idx == PIRB_IDX_EVT_EN);
   assign rif.hit = sel_req0 || sel_req1 || sel_req2 || sel_ack0 || sel_ack1 ||
      sel_ack2 || sel_vec || sel_stat || sel_clr || sel_en;
   assign wr_bits = rif.wr_stb ? (rif.wdata & rif.wmask) : 16'h0;

   // ==========================================================
   // Software set and acknowledge words
   logic [47:0] sw_set, sw_ack, hw_set, core_clr, set_all, clr_all;

   // R2: ones written to a request register raise requests
   // R3: zeros form no set and no clear
   // R4: reserved bits fall out through the implemented mask
   assign sw_set = {sel_req2 ? wr_bits : 16'h0, sel_req1 ? wr_bits : 16'h0,
      sel_req0 ? wr_bits : 16'h0} & PIRB_IMPL;
   // R15: ones written to an acknowledge register clear requests
   assign sw_ack = {sel_ack2 ? wr_bits : 16'h0, sel_ack1 ? wr_bits : 16'h0,
      sel_ack0 ? wr_bits : 16'h0} & PIRB_IMPL;
   // R1: peripheral requests mark their bits pending
   assign hw_set = SRC_REQ_I & PIRB_IMPL;

   // ==========================================================
   // Core acknowledge
   logic ack_found;
   logic [5:0] ack_idx;
   logic core_hit, core_phantom;

   pirb_prio u_prio (
      .pend_i(pend),
      .level_i(CORE_ACK_LEVEL_I),
      .found_o(ack_found),
      .idx_o(ack_idx)
   );

   assign core_hit = CORE_ACK_I && ack_found;
   assign core_phantom = CORE_ACK_I && !ack_found;
   // R15: the chosen source is cleared by the core acknowledge
   assign core_clr = core_hit ? (48'h1 << ack_idx) : 48'h0;
   assign set_all = hw_set | sw_set;
   assign clr_all = sw_ack | core_clr;

   // R1: a new request in the clearing cycle still wins
   assign next_pend = (pend & ~clr_all) | set_all;

   // R14: vector of the best source, or phantom when none pends
   assign next_vector = core_hit ? 16'(VECTOR_BASE + {10'h0, ack_idx}) :
      core_phantom ? PHANTOM_VECTOR : vector;

   // ==========================================================
   // Events
   logic [2:0] evt_set, evt_clr;

   assign evt_set[PIRB_EVT_ACK] = core_hit;
   assign evt_set[PIRB_EVT_PHANTOM] = core_phantom;
   // A request already pending is lost as a separate event
   assign evt_set[PIRB_EVT_OVERRUN] = |(hw_set & pend);
   assign evt_clr = sel_clr ? wr_bits[2:0] : 3'h0;
   assign next_evt_status = (evt_status & ~evt_clr) | evt_set;
   assign next_evt_enable = (rif.wr_stb && sel_en) ?
      ((evt_enable & ~rif.wmask[2:0]) | (rif.wdata[2:0] & rif.wmask[2:0])) : evt_enable;

   // ==========================================================
   // Read data
   always_comb begin
      if (sel_req0) begin
         // R1: pending state reads back directly
         rif.rdata = pend[15:0];
      end else if (sel_req1) begin
         // R4: reserved bit is held at zero
         rif.rdata = pend[31:16] & PIRB_IMPL1;
      end else if (sel_req2) begin
         rif.rdata = pend[47:32] & PIRB_IMPL2;
      end else if (sel_vec) begin
         rif.rdata = vector;
      end else if (sel_stat) begin
         rif.rdata = {13'h0, evt_status};
      end else if (sel_en) begin
         rif.rdata = {13'h0, evt_enable};
      end else begin
         // Acknowledge and clear registers read as zero
         rif.rdata = 16'h0;
      end
   end

   // ==========================================================
   // Flops
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         // R5: every request clears at reset
         pend <= PIRB_PEND_RST;
         vector <= PIRB_VEC_RST;
         evt_status <= PIRB_EVT_RST;
         evt_enable <= PIRB_EVT_RST;
      end else begin
         pend <= next_pend;
         vector <= next_vector;
         evt_status <= next_evt_status;
         evt_enable <= next_evt_enable;
      end
   end

   // Outputs follow next values so they line up with the registers
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         CORE_LEVEL_O <= 6'h00;
         SRC_ACK_O <= 48'h0;
         VECTOR_O <= PIRB_VEC_RST;
         IRQ_O <= 1'b0;
      end else begin
         // R6 R7 R8 R9 R10 R11 R12 R13 R16: level map ORs pending bits
         CORE_LEVEL_O <= pirb_level_hits(next_pend);
         // R15: acknowledge pulse back to the peripheral
         SRC_ACK_O <= clr_all;
         VECTOR_O <= next_vector;
         IRQ_O <= |(next_evt_status & next_evt_enable);
      end
   end
endmodule
`default_nettype wire

// file: tb/pirb_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker on the top ports
module pirb_bank_sva
   import pirb_pkg::*;
#(
   parameter logic [15:0] VECTOR_BASE = 16'h0001,
   parameter logic [15:0] PHANTOM_VECTOR = 16'h0000
) (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic [47:0] SRC_REQ_I,
   input wire logic [47:0] SRC_ACK_O,
   input wire logic CORE_ACK_I,
   input wire logic [2:0] CORE_ACK_LEVEL_I,
   input wire logic [5:0] CORE_LEVEL_O,
   input wire logic [15:0] VECTOR_O,
   input wire logic AXI_BVALID_O
);
   logic [5:0] req_hits;
   logic [15:0] ack_idx;
   logic [47:0] lvl_mask;
   always_comb begin
      req_hits = 6'h00;
      ack_idx = 16'h0000;
      for (int l = 0; l < 6; l++) begin
         req_hits[l] = |(SRC_REQ_I & PIRB_LEVEL_MAP[l]);
      end
      for (int b = 47; b >= 0; b--) begin
         if (SRC_ACK_O[b]) ack_idx = 16'(b);
      end
   end
   // Codes 0 and 7 name no level, so nothing may be acked for them
   assign lvl_mask = (CORE_ACK_LEVEL_I inside {[3'h1:3'h6]}) ?
      PIRB_LEVEL_MAP[CORE_ACK_LEVEL_I - 3'h1] : 48'h0;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RSTN_I);
   sequence s_ack_hit;
      CORE_ACK_I ##1 (SRC_ACK_O != 48'h0);
   endsequence
   sequence s_ack_miss;
      CORE_ACK_I ##1 (SRC_ACK_O == 48'h0);
   endsequence
   // ==========
   // Properties
   property p_rst_clear;
      $rose(RSTN_I) |-> CORE_LEVEL_O == 6'h00 && SRC_ACK_O == 48'h0 && VECTOR_O == 16'h0000;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear");
   property p_lvl_set;
      req_hits != 6'h00 |=> (CORE_LEVEL_O & $past(req_hits)) == $past(req_hits);
   endproperty
   a_lvl_set: assert property (p_lvl_set) else $error("level not raised");
   property p_lvl_rise;
      (CORE_LEVEL_O & ~$past(CORE_LEVEL_O) & ~$past(req_hits)) != 6'h00 |-> $rose(AXI_BVALID_O);
   endproperty
   a_lvl_rise: assert property (p_lvl_rise) else $error("level without cause");
   property p_lvl_fall;
      ($past(CORE_LEVEL_O) & ~CORE_LEVEL_O) != 6'h00 |-> $past(CORE_ACK_I) || $rose(AXI_BVALID_O);
   endproperty
   a_lvl_fall: assert property (p_lvl_fall) else $error("level dropped alone");
   property p_ack_cause;
      SRC_ACK_O != 48'h0 |-> $past(CORE_ACK_I) || $rose(AXI_BVALID_O);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without cause");
   property p_ack_hit;
      s_ack_hit |-> $onehot(SRC_ACK_O) && VECTOR_O == VECTOR_BASE + ack_idx
         && (SRC_ACK_O & $past(lvl_mask)) == SRC_ACK_O;
   endproperty
   a_ack_hit: assert property (p_ack_hit) else $error("wrong source acked");
   property p_ack_miss;
      s_ack_miss |-> VECTOR_O == PHANTOM_VECTOR;
   endproperty
   a_ack_miss: assert property (p_ack_miss) else $error("phantom vector wrong");
   property p_vec_hold;
      !CORE_ACK_I |=> $stable(VECTOR_O);
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
endmodule

bind pirb_bank pirb_bank_sva #(.VECTOR_BASE(VECTOR_BASE), .PHANTOM_VECTOR(PHANTOM_VECTOR))
   pirb_bank_sva_inst (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .SRC_REQ_I(SRC_REQ_I),
   .SRC_ACK_O(SRC_ACK_O), .CORE_ACK_I(CORE_ACK_I), .CORE_ACK_LEVEL_I(CORE_ACK_LEVEL_I),
   .CORE_LEVEL_O(CORE_LEVEL_O), .VECTOR_O(VECTOR_O), .AXI_BVALID_O(AXI_BVALID_O));
`default_nettype wire

// file: tb/pirb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Core side: acks the lowest requesting level after a delay
module pirb_core_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] level_i,
   input wire logic [5:0] mask_i,
   input wire logic [3:0] delay_i,
   input wire logic phantom_i,
   output logic ack_o,
   output logic [2:0] ack_lvl_o
);
   logic [3:0] cnt;
   logic [5:0] hit;
   logic [2:0] best;
   assign hit = level_i & mask_i;
   always_comb begin
      best = 3'h0;
      for (int l = 5; l >= 0; l--) begin
         if (hit[l]) best = 3'(l + 1);
      end
   end
   // Idle a cycle after each ack, so a dropped level is never acked twice
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         ack_lvl_o <= 3'h0;
         cnt <= 4'h0;
      end else if (ack_o) begin
         ack_o <= 1'b0;
         cnt <= 4'h0;
      end else if (phantom_i) begin
         ack_o <= 1'b1;
         ack_lvl_o <= 3'h6;
      end else if (hit != 6'h00 && cnt >= delay_i) begin
         ack_o <= 1'b1;
         ack_lvl_o <= best;
      end else begin
         cnt <= (hit != 6'h00) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// file: tb/test_pirb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_pirb_bank;
   import pirb_pkg::*;
   localparam logic [15:0] VB = 16'h0040;
   localparam logic [15:0] PV = 16'h0000;
   // Bit 15 of the upper two registers is reserved
   localparam logic [47:0] IMPL = 48'h7fff_7fff_ffff;
   logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, phantom = 1'b0;
   logic [17:0] awaddr = 18'h0, araddr = 18'h0;
   logic [31:0] wdata = 32'h0;
   logic [47:0] src = 48'h0;
   logic [5:0] mask = 6'h0;
   logic [3:0] dly = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, cack, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [47:0] sack, pat, seen;
   logic [5:0] lvl, lexp;
   logic [2:0] clvl;
   logic [15:0] vec, d;
   int r;
   int failures = 0;
   int samples_checked = 0;

   pirb_bank #(.VECTOR_BASE(VB), .PHANTOM_VECTOR(PV)) pirb_bank_inst (.CLK_I(clk),
      .RSTN_I(rstn), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
      .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'h3), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
      .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
      .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
      .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
      .SRC_REQ_I(src), .SRC_ACK_O(sack), .CORE_ACK_I(cack), .CORE_ACK_LEVEL_I(clvl),
      .CORE_LEVEL_O(lvl), .VECTOR_O(vec), .IRQ_O(irq));
   pirb_core_model pirb_core_model_inst (.clk_i(clk), .rstn_i(rstn), .level_i(lvl),
      .mask_i(mask), .delay_i(dly), .phantom_i(phantom), .ack_o(cack), .ack_lvl_o(clvl));

   initial begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic [5:0] lvl_of(input int b);
      int k;
      k = b % 16;
      if (b < 16) return (k < 9) ? 6'h01 : 6'h02;
      if (b < 32) return (k < 4) ? 6'h04 : (k < 7) ? 6'h08 : (k < 12) ? 6'h10 :
         (k < 15) ? 6'h20 : 6'h00;
      return (k == 0) ? 6'h01 : (k < 8) ? 6'h02 : (k < 12) ? 6'h04 : (k < 15) ? 6'h08 : 6'h00;
   endfunction

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Write sends d; read expects d. Each channel drops valid on its own ready
   task automatic xfer(input bit w, input logic [15:0] idx, input logic [15:0] d,
      input logic [1:0] er, input string nm);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      araddr <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (arvalid && arready) arvalid <= 1'b0;
         if ((bvalid && bready) || (rvalid && rready)) begin
            done = 1'b1;
            bready <= 1'b0;
            rready <= 1'b0;
            chk(nm, 48'(er), w ? 48'(bresp) : 48'(rresp));
            if (!w) chk(nm, 48'(d), 48'(rdata));
         end
      end
   endtask

   initial begin
      void'($urandom(7));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         xfer(0, PIRB_IDX_REQ0 + 16'(i), 16'h0000, PIRB_RESP_OKAY, "request reset");
      end
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         r = i % 3;
         d = (i < 3) ? 16'hffff : 16'($urandom());
         pat = 48'(d & IMPL[r * 16 +: 16]) << (r * 16);
         lexp = 6'h00;
         for (int b = 0; b < 48; b++) begin
            if (pat[b]) lexp = lexp | lvl_of(b);
         end
         xfer(1, PIRB_IDX_REQ0 + 16'(r), d, PIRB_RESP_OKAY, "request set");
         xfer(1, PIRB_IDX_REQ0 + 16'(r), 16'h0000, PIRB_RESP_OKAY, "request zero");
         xfer(0, PIRB_IDX_REQ0 + 16'(r), pat[r * 16 +: 16], PIRB_RESP_OKAY, "request");
         @(negedge clk);
         chk("levels from writes", 48'(lexp), 48'(lvl));
         xfer(1, PIRB_IDX_ACK0 + 16'(r), 16'hffff, PIRB_RESP_OKAY, "ack write");
         xfer(0, PIRB_IDX_REQ0 + 16'(r), 16'h0000, PIRB_RESP_OKAY, "after ack");
      end
      $display("test software requests done");
      mask <= 6'h3f;
      dly <= 4'h2;
      for (int b = 0; b < 48; b++) begin
         @(posedge clk);
         src <= 48'h1 << b;
         @(posedge clk);
         src <= 48'h0;
         @(negedge clk);
         chk("level of source", 48'(lvl_of(b)), 48'(lvl));
         seen = 48'h0;
         for (int n = 0; n < 12 && seen == 48'h0; n++) begin
            @(negedge clk);
            seen = sack;
         end
         chk("acked source", (lvl_of(b) != 6'h00) ? 48'h1 << b : 48'h0, seen);
         if (seen != 48'h0) chk("vector", 48'(VB + 16'(b)), 48'(vec));
         chk("level after ack", 48'h0, 48'(lvl));
      end
      $display("test hardware requests done");
      mask <= 6'h00;
      xfer(0, PIRB_IDX_EVT_STAT, 16'h0001, PIRB_RESP_OKAY, "event status");
      phantom <= 1'b1;
      @(posedge clk);
      phantom <= 1'b0;
      repeat (4) @(negedge clk);
      chk("phantom vector", 48'(PV), 48'(vec));
      xfer(0, PIRB_IDX_VEC, PV, PIRB_RESP_OKAY, "vector read");
      xfer(1, PIRB_IDX_EVT_EN, 16'h0002, PIRB_RESP_OKAY, "event enable");
      @(negedge clk);
      chk("irq raised", 48'h1, 48'(irq));
      xfer(1, PIRB_IDX_EVT_EN, 16'h0000, PIRB_RESP_OKAY, "event mask");
      @(negedge clk);
      chk("irq masked", 48'h0, 48'(irq));
      xfer(1, PIRB_IDX_EVT_EN, 16'h0007, PIRB_RESP_OKAY, "event enable");
      xfer(1, PIRB_IDX_EVT_CLR, 16'h0003, PIRB_RESP_OKAY, "event clear");
      xfer(0, PIRB_IDX_EVT_STAT, 16'h0000, PIRB_RESP_OKAY, "status cleared");
      chk("irq cleared", 48'h0, 48'(irq));
      xfer(1, 16'h7030, 16'h0001, PIRB_RESP_SLVERR, "unmapped write");
      xfer(0, 16'h7030, 16'h0000, PIRB_RESP_SLVERR, "unmapped read");
      $display("test events done");
      dly <= 4'($urandom_range(3, 0));
      pat = {16'($urandom()), 32'($urandom())} & IMPL;
      src <= pat;
      repeat (2) @(posedge clk);
      src <= 48'h0;
      mask <= 6'h3f;
      seen = 48'h0;
      for (int n = 0; n < 800 && (n < 3 || lvl != 6'h00); n++) begin
         @(negedge clk);
         seen = seen | sack;
      end
      chk("drained sources", pat, seen);
      chk("levels drained", 48'h0, 48'(lvl));
      xfer(0, PIRB_IDX_EVT_STAT, (pat != 48'h0) ? 16'h0005 : 16'h0000, PIRB_RESP_OKAY, "overrun");
      $display("test random drain done");
      end_sim();
   end

   initial begin
      // Whole run needs about a thousand cycles
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end
endmodule
`default_nettype wire
